/* hw/dmb_pkg.sv */
// shared constants, types and state encodings for the dual-die memory bus sideband
package dmb_pkg;

  // core clock and derived timing
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned POR_TIME_US     = 300;
  localparam int unsigned POR_CYCLES      = (POR_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PE_TIME_US      = 100;
  localparam int unsigned PE_CYCLES       = (PE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TIMEOUT_STEP_NS = 1000;
  localparam int unsigned STEP_CYCLES     = (TIMEOUT_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // transaction framing on the link
  localparam int unsigned CA_BYTES   = 6;
  localparam int unsigned LAT_CYCLES = 6;
  localparam int unsigned READ_BIT   = 7;
  localparam int unsigned MEM_DEPTH  = 16;
  localparam int unsigned CNT_W      = 32;

  // reset values
  localparam logic [7:0]  DQ_RESET      = 8'h00;
  localparam logic [15:0] TIMEOUT_RESET = 16'h0000;

  // one-hot states of a die's link engine
  typedef enum logic [3:0] {
    XF_IDLE = 4'b0001,
    XF_CMD  = 4'b0010,
    XF_LAT  = 4'b0100,
    XF_DATA = 4'b1000
  } dmb_xfer_t;

  // one-hot states of the flash power-on sequencer
  typedef enum logic [2:0] {
    PR_POR   = 3'b001,
    PR_HOLD  = 3'b010,
    PR_READY = 3'b100
  } dmb_por_t;

  // what one die drives onto the shared pins
  typedef struct packed {
    logic [7:0] dq;
    logic       dq_oe;
    logic       strobe;
    logic       strobe_oe;
  } dmb_drive_t;

endpackage : dmb_pkg

/* hw/dmb_die_port.sv */
// link-side transaction engine of one die: select framing, command capture, latency, data
`timescale 1ns/1ps
module dmb_die_port
  import dmb_pkg::*;
#(
  parameter bit          IS_RAM = 1'b0,
  parameter int unsigned CA_N   = CA_BYTES,
  parameter int unsigned LAT_N  = LAT_CYCLES,
  parameter int unsigned DEPTH  = MEM_DEPTH
)(
  // link clock and reset
  input  wire logic       bus_clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       select_n,
  input  wire logic       hold,
  input  wire logic       extra_lat,
  // shared pins, inbound
  input  wire logic [7:0] dq_in,
  input  wire logic       strobe_in,
  // outbound
  output dmb_drive_t      drv,
  output logic            active,
  output logic            wr_done
);

  localparam int unsigned AW = $clog2(DEPTH);

  dmb_xfer_t         state_r;
  dmb_xfer_t         state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic              sel_q_r;
  logic              extra_r;
  logic              is_read_r;
  logic [AW-1:0]     addr_r;
  logic [7:0]        mem_r [DEPTH];
  dmb_drive_t        drv_r;
  logic              wr_done_r;
  logic              start;
  logic              stop;
  logic [CNT_W-1:0]  lat_total;

  // select edges frame a transaction
  assign start     = sel_q_r & ~select_n;
  assign stop      = ~sel_q_r & select_n;
  assign lat_total = extra_r ? CNT_W'(2 * LAT_N) : CNT_W'(LAT_N);

  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
      sel_q_r <= 1'b1;
    else
      sel_q_r <= select_n;
  end

  // next state; a raised select or hold always returns to idle
  always_comb
  begin
    state_nxt = state_r;
    if (hold || select_n)
      state_nxt = XF_IDLE;
    else
    begin
      case (state_r)
        XF_IDLE: if (start) state_nxt = XF_CMD;
        XF_CMD:  if (cnt_r == CNT_W'(CA_N - 1)) state_nxt = XF_LAT;
        XF_LAT:  if (cnt_r == lat_total - CNT_W'(1)) state_nxt = XF_DATA;
        XF_DATA: state_nxt = XF_DATA;
        default: state_nxt = XF_IDLE;
      endcase
    end
  end

  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= XF_IDLE;
    else
      state_r <= state_nxt;
  end

  // byte counter restarts at every state change
  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (state_nxt != state_r)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + CNT_W'(1);
  end

  // latency flag is caught at the select edge so it cannot change mid-frame
  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
      extra_r <= 1'b0;
    else if (state_r == XF_IDLE && start)
      extra_r <= extra_lat;
  end

  // command-address bytes arrive on the shared data lines
  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      is_read_r <= 1'b0;
      addr_r    <= '0;
    end
    else if (state_r == XF_CMD)
    begin
      if (cnt_r == '0)
        is_read_r <= dq_in[READ_BIT];
      if (cnt_r == CNT_W'(CA_N - 1))
        addr_r <= dq_in[AW-1:0];
    end
    else if (state_r == XF_DATA)
      addr_r <= addr_r + AW'(1);
  end

  // write data; on the ram die a high strobe masks the byte
  always_ff @(posedge bus_clk)
  begin
    if (state_r == XF_DATA && !select_n && !is_read_r && !(IS_RAM && strobe_in))
      mem_r[addr_r] <= dq_in;
  end

  // pin drive registered from the next state so it lines up with the byte
  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
      drv_r <= '{dq: DQ_RESET, dq_oe: 1'b0, strobe: 1'b0, strobe_oe: 1'b0};
    else
    begin
      drv_r.strobe_oe <= (state_nxt == XF_CMD) || (state_nxt == XF_DATA && is_read_r);
      drv_r.dq_oe     <= (state_nxt == XF_DATA) && is_read_r;
      if (state_nxt == XF_CMD)
        drv_r.strobe <= (state_r == XF_IDLE) ? extra_lat : extra_r;
      else if (state_nxt == XF_DATA && state_r == XF_DATA)
        drv_r.strobe <= ~drv_r.strobe;
      else
        drv_r.strobe <= 1'b0;
      drv_r.dq <= mem_r[(state_r == XF_DATA) ? addr_r + AW'(1) : addr_r];
    end
  end

  // a completed write frame is reported once
  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_done_r <= 1'b0;
    else
      wr_done_r <= stop && state_r == XF_DATA && !is_read_r && !hold;
  end

  assign drv     = drv_r;
  assign active  = (state_r != XF_IDLE);
  assign wr_done = wr_done_r;

endmodule : dmb_die_port

/* hw/dmb_sideband.sv */
// top of the shared memory bus: die routing, reset pins, event pin and flash sequencing
//
// Notes on behaviour
// - command-address and data bytes all travel over the shared eight data lines
// - flash pulls the event pin low on an internal event, otherwise floats it
// - a low hardware reset reinitialises the flash and returns it to idle
// - while hardware reset is low, strobe and data lines are released
// - the reset input reads high when nobody drives it
// - hardware reset idles only the flash; the ram keeps its state, but its pin drive is released too
// - the reset output is held low during the internal power-on reset
// - after power-on reset the reset output stays low for a user timeout
// - when the reset output releases, the flash is idle and ready at once
// - program or erase keeps running after flash deselect; ram stays usable
// - a falling select starts a transaction, a rising select ends it
// - at transaction start the die drives the strobe as extra-latency flag
// - reads drive strobe with data; ram writes take the strobe as mask
`timescale 1ns/1ps
module dmb_sideband
  import dmb_pkg::*;
#(
  parameter int unsigned POR_N   = POR_CYCLES,
  parameter int unsigned PE_N    = PE_CYCLES,
  parameter int unsigned STEP_N  = STEP_CYCLES,
  parameter int unsigned CA_N    = CA_BYTES,
  parameter int unsigned LAT_N   = LAT_CYCLES,
  parameter int unsigned DEPTH   = MEM_DEPTH
)(
  // core clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // link clock and selects
  input  wire logic        bus_clk,
  input  wire logic        flash_select_n,
  input  wire logic        ram_select_n,
  // shared data lines
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe,
  // read-write data strobe
  input  wire logic        rw_data_strobe_in,
  output logic             rw_data_strobe_out,
  output logic             rw_data_strobe_oe,
  // hardware reset pin as seen from outside
  input  wire logic        hw_reset_n_in,
  input  wire logic        hw_reset_n_oe,
  // open-drain event pin
  output logic             event_n_out,
  output logic             event_n_oe,
  // open-drain reset output
  output logic             por_reset_out_n_out,
  output logic             por_reset_out_n_oe,
  // core-side configuration and events
  input  wire logic [15:0] por_hold_time,
  input  wire logic        flash_event,
  input  wire logic        event_clear,
  input  wire logic        ram_extra_latency,
  // core-side status
  output logic             flash_ready,
  output logic             flash_busy,
  output logic             flash_reinit,
  output logic             event_pending,
  output logic             select_collision
);

  // core clock domain registers and nets
  logic              hwr_pin;
  logic              hwr_s1_r;
  logic              hwr_s2_r;
  logic              hw_reset_act;
  dmb_por_t          por_r;
  logic [CNT_W-1:0]  por_cnt_r;
  logic [15:0]       timeout_r;
  logic [CNT_W-1:0]  hold_total;
  logic              ready_r;
  logic              reinit_r;
  logic              por_oe_r;
  logic [2:0]        wr_tgl_s_r;
  logic              wr_pulse;
  logic              busy_r;
  logic [CNT_W-1:0]  pe_cnt_r;
  logic              pe_done;
  logic              event_r;
  logic              coll_s1_r;
  logic              coll_s2_r;

  // link clock domain registers and nets
  logic              rdy_b1_r;
  logic              rdy_b2_r;
  logic              lat_b1_r;
  logic              lat_b2_r;
  logic              rst_b1_r;
  logic              rst_b2_r;
  logic              collide;
  logic              coll_b_r;
  logic              wr_tgl_r;
  logic              flash_hold;
  dmb_drive_t        f_drv;
  dmb_drive_t        r_drv;
  logic              f_active;
  logic              r_active;
  logic              f_wr_done;
  logic              r_wr_done_unused;

  // an undriven reset pin floats to the inactive level through the weak pull-up
  assign hwr_pin = hw_reset_n_oe ? hw_reset_n_in : 1'b1;

  // synchronisers into the core domain; only the last stages feed logic, the last two for the write toggle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hwr_s1_r   <= 1'b1;
      hwr_s2_r   <= 1'b1;
      wr_tgl_s_r <= '0;
      coll_s1_r  <= 1'b0;
      coll_s2_r  <= 1'b0;
    end
    else
    begin
      hwr_s1_r   <= hwr_pin;
      hwr_s2_r   <= hwr_s1_r;
      wr_tgl_s_r <= {wr_tgl_s_r[1:0], wr_tgl_r};
      coll_s1_r  <= coll_b_r;
      coll_s2_r  <= coll_s1_r;
    end
  end

  assign hw_reset_act = ~hwr_s2_r;

  // power-on sequencer: internal reset, user timeout, then ready
  assign hold_total = CNT_W'(timeout_r) * CNT_W'(STEP_N);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_r     <= PR_POR;
      por_cnt_r <= '0;
    end
    else
    begin
      case (por_r)
        PR_POR:
        begin
          if (por_cnt_r >= CNT_W'(POR_N - 1))
          begin
            por_r     <= PR_HOLD;
            por_cnt_r <= '0;
          end
          else
            por_cnt_r <= por_cnt_r + CNT_W'(1);
        end
        PR_HOLD:
        begin
          if (por_cnt_r >= hold_total)
            por_r <= PR_READY;
          else
            por_cnt_r <= por_cnt_r + CNT_W'(1);
        end
        PR_READY: por_r <= PR_READY;
        default:  por_r <= PR_POR;
      endcase
    end
  end

  // the timeout follows the input during the internal reset and holds the value caught as it completes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timeout_r <= TIMEOUT_RESET;
    else if (por_r == PR_POR)
      timeout_r <= por_hold_time;
  end

  // reset output driven low until the sequencer reaches ready
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      por_oe_r <= 1'b1;
    else
      por_oe_r <= (por_r != PR_READY);
  end

  // ready in the same cycle the reset output lets go; reinit moves on the edge ready drops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_r  <= 1'b0;
      reinit_r <= 1'b0;
    end
    else
    begin
      ready_r  <= (por_r != PR_READY) ? 1'b0 : ~hw_reset_act;
      reinit_r <= hw_reset_act;
    end
  end

  // a change of the write toggle marks one finished flash write frame
  assign wr_pulse = wr_tgl_s_r[2] ^ wr_tgl_s_r[1];

  // program/erase runs on the core clock, independent of the flash select
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r   <= 1'b0;
      pe_cnt_r <= '0;
    end
    else if (hw_reset_act)
    begin
      busy_r   <= 1'b0;
      pe_cnt_r <= '0;
    end
    else if (!busy_r)
    begin
      busy_r   <= wr_pulse && ready_r;
      pe_cnt_r <= '0;
    end
    else if (pe_cnt_r >= CNT_W'(PE_N - 1))
      busy_r <= 1'b0;
    else
      pe_cnt_r <= pe_cnt_r + CNT_W'(1);
  end

  assign pe_done = busy_r && !hw_reset_act && (pe_cnt_r >= CNT_W'(PE_N - 1));

  // sticky event: busy-to-ready or a core event; a set beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      event_r <= 1'b0;
    else if (pe_done || flash_event)
      event_r <= 1'b1;
    else if (event_clear)
      event_r <= 1'b0;
  end

  // link domain: ready, latency and reset crossings, plus the collision flag
  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdy_b1_r <= 1'b0;
      rdy_b2_r <= 1'b0;
      lat_b1_r <= 1'b0;
      lat_b2_r <= 1'b0;
      rst_b1_r <= 1'b0;
      rst_b2_r <= 1'b0;
      coll_b_r <= 1'b0;
    end
    else
    begin
      rdy_b1_r <= ready_r;
      rdy_b2_r <= rdy_b1_r;
      lat_b1_r <= ram_extra_latency;
      lat_b2_r <= lat_b1_r;
      rst_b1_r <= hw_reset_act;
      rst_b2_r <= rst_b1_r;
      coll_b_r <= collide;
    end
  end

  // the flash engine idles while not ready, which also covers a host that starts too early
  assign flash_hold = ~rdy_b2_r | rst_b2_r;

  // a double select is illegal; neither die answers it so the lines never fight
  assign collide = ~flash_select_n & ~ram_select_n;

  // flash write frames hand off to the program/erase timer as a toggle
  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_tgl_r <= 1'b0;
    else if (f_wr_done)
      wr_tgl_r <= ~wr_tgl_r;
  end

  // flash die: no refresh, so never asks for extra latency
  dmb_die_port #(
    .IS_RAM    (1'b0),
    .CA_N      (CA_N),
    .LAT_N     (LAT_N),
    .DEPTH     (DEPTH)
  ) u_flash (
    .bus_clk   (bus_clk),
    .rst_n     (rst_n),
    .select_n  (flash_select_n | collide),
    .hold      (flash_hold),
    .extra_lat (1'b0),
    .dq_in     (dq_in),
    .strobe_in (rw_data_strobe_in),
    .drv       (f_drv),
    .active    (f_active),
    .wr_done   (f_wr_done)
  );

  // ram die: never held, the hardware reset does not reach it
  dmb_die_port #(
    .IS_RAM    (1'b1),
    .CA_N      (CA_N),
    .LAT_N     (LAT_N),
    .DEPTH     (DEPTH)
  ) u_ram (
    .bus_clk   (bus_clk),
    .rst_n     (rst_n),
    .select_n  (ram_select_n | collide),
    .hold      (1'b0),
    .extra_lat (lat_b2_r),
    .dq_in     (dq_in),
    .strobe_in (rw_data_strobe_in),
    .drv       (r_drv),
    .active    (r_active),
    .wr_done   (r_wr_done_unused)
  );

  // shared pins: the active die drives; hardware reset releases them from the core side, as the link clock may stop
  assign dq_out             = f_active ? f_drv.dq : r_drv.dq;
  assign dq_oe              = (f_drv.dq_oe | r_drv.dq_oe) & ~(hw_reset_act | reinit_r);
  assign rw_data_strobe_out = f_active ? f_drv.strobe : r_drv.strobe;
  assign rw_data_strobe_oe  = (f_drv.strobe_oe | r_drv.strobe_oe) & ~(hw_reset_act | reinit_r);

  // open-drain pins only ever pull low
  assign event_n_out         = 1'b0;
  assign event_n_oe          = event_r;
  assign por_reset_out_n_out = 1'b0;
  assign por_reset_out_n_oe  = por_oe_r;

  // status
  assign flash_ready      = ready_r;
  assign flash_busy       = busy_r;
  assign flash_reinit     = reinit_r;
  assign event_pending    = event_r;
  assign select_collision = coll_s2_r;

endmodule : dmb_sideband

/* bench/dmb_sideband_asserts.sv */
// checker for the sideband pins and status of the dual-die bus
`timescale 1ns/1ps
module dmb_sideband_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and status
  input wire logic dq_oe,
  input wire logic rw_data_strobe_oe,
  input wire logic event_n_out,
  input wire logic event_n_oe,
  input wire logic por_reset_out_n_out,
  input wire logic por_reset_out_n_oe,
  input wire logic flash_event,
  input wire logic flash_ready,
  input wire logic flash_reinit,
  input wire logic event_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // pins and readiness under hardware reset
  a_hwrst_release: assert property (flash_reinit |-> !dq_oe && !rw_data_strobe_oe)
    else $error("bus pins driven during hardware reset");
  a_reinit_idle: assert property (flash_reinit |-> !flash_ready)
    else $error("flash ready during hardware reset");
  // reset output sequencing; por time is longer than the repetition
  a_por_hold: assert property ($rose(rst_n) |-> por_reset_out_n_oe [*8])
    else $error("reset output released early");
  a_release_ready: assert property ($fell(por_reset_out_n_oe) |-> flash_ready)
    else $error("flash not ready at reset output release");
  a_por_out_once: assert property (!por_reset_out_n_oe |=> !por_reset_out_n_oe)
    else $error("reset output asserted again");
  a_ready_after: assert property (flash_ready |-> !por_reset_out_n_oe)
    else $error("flash ready while reset output low");
  a_por_out_low: assert property (!por_reset_out_n_out)
    else $error("reset output drives high");
  // event pin is open drain and follows the flag
  a_event_set: assert property (flash_event |=> event_pending)
    else $error("event not flagged");
  a_event_pin: assert property (event_n_oe == event_pending && !event_n_out)
    else $error("event pin wrong");
  c_release: cover property ($fell(por_reset_out_n_oe));
  c_event: cover property ($rose(event_pending));
  c_reinit: cover property ($rose(flash_reinit));
endmodule : dmb_sideband_asserts

bind dmb_sideband dmb_sideband_asserts i_chk (.clk, .rst_n, .dq_oe, .rw_data_strobe_oe, .event_n_out, .event_n_oe,
  .por_reset_out_n_out, .por_reset_out_n_oe, .flash_event, .flash_ready, .flash_reinit, .event_pending);

/* bench/dmb_host_model.sv */
// host model: link clock within frames, selects, command and data bytes
`timescale 1ns/1ps
module dmb_host_model
  import dmb_pkg::*;
(
  // link clock and selects
  output logic            bus_clk,
  output logic            f_sel_n,
  output logic            r_sel_n,
  // host drive of shared lines
  output logic      [7:0] dq,
  output logic            dq_oe,
  output logic            stb,
  output logic            stb_oe,
  // wire levels
  input  wire logic [7:0] dq_w,
  input  wire logic       stb_w
);
  // the clock stands still except while the idle task runs it
  initial
  begin
    bus_clk = 1'b0;
    f_sel_n = 1'b1;
    r_sel_n = 1'b1;
    dq_oe = 1'b0;
    stb_oe = 1'b0;
  end
  // host changes land at the falling edge, half a cycle from sampling
  task automatic idle(input int n);
    repeat (n)
    begin
      #15 bus_clk = 1'b1;
      #15 bus_clk = 1'b0;
    end
  endtask : idle
  // selects set together, so a collision can be made on purpose
  task automatic sel(input logic f, input logic r);
    f_sel_n = f;
    r_sel_n = r;
  endtask : sel
  task automatic frame(input logic ram, input logic rd, input logic [3:0] a, input logic [31:0] wd,
                       input logic [3:0] m, output logic [31:0] rdat, output logic [3:0] rstb, output logic flag);
    sel(ram, !ram);
    idle(1);
    flag = stb_w;
    dq_oe = 1'b1;
    for (int i = 0; i < CA_BYTES; i++)
    begin
      dq = (i == 0) ? {rd, 7'h00} : (i == CA_BYTES - 1) ? {4'h0, a} : 8'h00;
      idle(1);
    end
    dq_oe = !rd;
    stb_oe = ram && !rd;
    idle(flag ? 2 * LAT_CYCLES : LAT_CYCLES);
    for (int k = 0; k < 4; k++)
    begin
      dq = wd[8*k +: 8];
      stb = m[k];
      rdat[8*k +: 8] = dq_w;
      rstb[k] = stb_w;
      idle(1);
    end
    dq_oe = 1'b0;
    stb_oe = 1'b0;
    sel(1'b1, 1'b1);
    idle(2);
  endtask : frame
endmodule : dmb_host_model

/* bench/testbench.sv */
// self-checking bench for the dual-die bus sideband
`timescale 1ns/1ps
module testbench;
  import dmb_pkg::*;
  // short counts keep the run brief; expectations use the same figures
  localparam int unsigned POR_T  = 20;
  localparam int unsigned STEP_T = 2;
  typedef struct packed {logic [3:0] a; logic [31:0] d; logic [3:0] m;} dmb_row_t;
  // address, data, mask: row two masks bytes 0 and 2, row three wraps
  localparam dmb_row_t ROWS [4] = '{'{4'h0, 32'h44332211, 4'h0}, '{4'h0, 32'haabbccdd, 4'h5},
                                    '{4'he, 32'h0f0e0d0c, 4'h0}, '{4'h4, 32'h87654321, 4'h0}};
  logic        clk = 1'b0, rst_n = 1'b0, hw_in = 1'b1, hw_oe = 1'b0;
  logic        fev = 1'b0, fclr = 1'b0, xlat = 1'b0;
  logic [15:0] tmo = 16'h0003;
  logic [7:0]  flt = 8'h5a;
  logic [7:0]  dq_out, h_dq, dq_w, shadow [16];
  logic        dq_oe, stb_out, stb_oe, h_dq_oe, h_stb, h_stb_oe, stb_w, flag;
  logic        bus_clk, f_sel_n, r_sel_n, po_oe, ready, busy, reinit, pend, coll, ev_out, ev_oe, po_out;
  logic [31:0] rdat, expv;
  logic [3:0]  rstb;
  int          n1, n2, n, cyc = 0, bad_count = 0, samples_checked = 0;

  always #2 clk = ~clk;
  // released lines carry a moving pattern, so a stale value never passes
  always @(posedge bus_clk) flt <= flt + 8'h3b;
  assign dq_w  = dq_oe ? dq_out : h_dq_oe ? h_dq : flt;
  assign stb_w = stb_oe ? stb_out : h_stb_oe ? h_stb : flt[0];

  dmb_sideband #(.POR_N(POR_T), .PE_N(400), .STEP_N(STEP_T)) i_dut (
    .clk(clk), .rst_n(rst_n), .bus_clk(bus_clk), .flash_select_n(f_sel_n), .ram_select_n(r_sel_n),
    .dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe), .rw_data_strobe_in(stb_w), .rw_data_strobe_out(stb_out),
    .rw_data_strobe_oe(stb_oe), .hw_reset_n_in(hw_in), .hw_reset_n_oe(hw_oe), .event_n_out(ev_out),
    .event_n_oe(ev_oe), .por_reset_out_n_out(po_out), .por_reset_out_n_oe(po_oe), .por_hold_time(tmo),
    .flash_event(fev),
    .event_clear(fclr), .ram_extra_latency(xlat), .flash_ready(ready), .flash_busy(busy),
    .flash_reinit(reinit), .event_pending(pend), .select_collision(coll));
  dmb_host_model i_host (.bus_clk(bus_clk), .f_sel_n(f_sel_n), .r_sel_n(r_sel_n), .dq(h_dq), .dq_oe(h_dq_oe),
    .stb(h_stb), .stb_oe(h_stb_oe), .dq_w(dq_w), .stb_w(stb_w));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // reset must see link edges too, so it is held past eight core cycles
  task automatic por_run(input logic [15:0] t, output int cnt);
    @(posedge clk) #1 rst_n = 1'b0;
    tmo = t;
    i_host.idle(3);
    check("rst_por_out", po_oe, 1);
    check("rst_ready", ready, 0);
    @(posedge clk) #1 rst_n = 1'b1;
    cnt = 0;
    while (po_oe === 1'b1 && cnt < 5000)
      @(posedge clk) #1 cnt++;
  endtask : por_run
  task automatic ram_check(input logic [3:0] a, input logic lf);
    i_host.frame(1'b1, 1'b1, a, 32'h0, 4'h0, rdat, rstb, flag);
    for (int k = 0; k < 4; k++)
      expv[8*k +: 8] = shadow[(a + k) % 16];
    check("ram_data", rdat, expv);
    check("ram_flag", flag, lf);
    check("read_strobe", rstb, 4'b1010);
  endtask : ram_check

  // hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    por_run(16'h0003, n1);
    check("ready_at_release", ready, 1);
    por_run(16'h0008, n2);
    check("hold_step", n2 - n1, 5 * STEP_T);
    check("hold_min", n1 >= POR_T + 3 * STEP_T, 1);
    $display("test por done");
    foreach (ROWS[i])
    begin
      i_host.frame(1'b1, 1'b0, ROWS[i].a, ROWS[i].d, ROWS[i].m, rdat, rstb, flag);
      for (int k = 0; k < 4; k++)
        if (!ROWS[i].m[k])
          shadow[(ROWS[i].a + k) % 16] = ROWS[i].d[8*k +: 8];
      ram_check(ROWS[i].a, 1'b0);
    end
    @(posedge clk) #1 xlat = 1'b1;
    i_host.idle(3);
    ram_check(4'h4, 1'b1);
    @(posedge clk) #1 xlat = 1'b0;
    i_host.idle(3);
    $display("test ram done");
    i_host.frame(1'b0, 1'b1, 4'h0, 32'h0, 4'h0, rdat, rstb, flag);
    check("flash_flag", flag, 0);
    check("flash_strobe", rstb, 4'b1010);
    i_host.frame(1'b0, 1'b0, 4'h2, 32'h01020304, 4'hf, rdat, rstb, flag);
    n = 0;
    while (busy !== 1'b1 && n < 50)
      @(posedge clk) #1 n++;
    ram_check(4'h4, 1'b0);
    check("busy_during_ram", busy, 1);
    n = 0;
    while (pend !== 1'b1 && n < 600)
      @(posedge clk) #1 n++;
    check("event_after_busy", pend, 1);
    check("busy_end", busy, 0);
    @(posedge clk) #1 fclr = 1'b1;
    @(posedge clk) #1 fclr = 1'b0;
    @(posedge clk) #1 check("event_cleared", pend, 0);
    check("event_pin_free", ev_oe, 0);
    fev = 1'b1;
    fclr = 1'b1;
    @(posedge clk) #1 fev = 1'b0;
    fclr = 1'b0;
    @(posedge clk) #1 check("set_wins", pend, 1);
    check("event_pin_low", {ev_out, ev_oe}, 2'b01);
    $display("test flash and event done");
    i_host.sel(1'b0, 1'b0);
    i_host.idle(6);
    check("collision", coll, 1);
    check("coll_quiet", {dq_oe, stb_oe}, 0);
    i_host.sel(1'b1, 1'b1);
    i_host.idle(3);
    $display("test collision done");
    @(posedge clk) #1 hw_oe = 1'b1;
    hw_in = 1'b0;
    repeat (4) @(posedge clk);
    #1 check("reinit", reinit, 1);
    check("reinit_ready", ready, 0);
    i_host.frame(1'b1, 1'b1, 4'h0, 32'h0, 4'h0, rdat, rstb, flag);
    @(posedge clk) #1 hw_in = 1'b1;
    repeat (8) @(posedge clk);
    #1 check("ready_again", ready, 1);
    check("por_stays", po_oe, 0);
    check("por_pin_level", po_out, 0);
    ram_check(4'h0, 1'b0);
    @(posedge clk) #1 hw_oe = 1'b0;
    hw_in = 1'b0;
    repeat (6) @(posedge clk);
    #1 check("pullup_idle", {reinit, ready}, 2'b01);
    $display("test hardware reset done");
    tally_and_finish();
  end
endmodule : testbench
